// >>> design/bsc_params.svh
// Constants for the beam smoothing and cascade trigger block
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH
`define BSC_SMOOTH_CFG_ADDR 16'h0047
`define BSC_SMOOTH_CFG_REGS 16'h0002
`define BSC_OBJ_INDEX 16'h2100
`define BSC_OBJ_SUB_SMOOTH 8'h03
`define BSC_OBJ_SUB_INV 8'h04
`define BSC_SMOOTH_POS 8
`define BSC_INV_POS 0
`define BSC_SMOOTH_CFG_RST 32'h0000_0000
`define BSC_FUNC_MASTER 1'b1
`define BSC_FUNC_SLAVE 1'b0
`define BSC_PIN_DIR_OUT 1'b0
`define BSC_PIN_DIR_IN 1'b1
`define BSC_PIN_OUT_TRIGGER 8'h03
`define BSC_PIN_IN_TRIGGER 8'h01
`define BSC_PIN_LIGHT_SW 1'b0
`define BSC_CLK_HZ 20000000
`define BSC_CYC_PER_US (`BSC_CLK_HZ / 1000000)
`define BSC_CYC_PER_MS (`BSC_CLK_HZ / 1000)
`define BSC_TRIG_PULSE_US 10
`define BSC_TRIG_PULSE_CYC (`BSC_TRIG_PULSE_US * `BSC_CYC_PER_US)
`endif

// >>> design/bsc_pkg.sv
// Types for the beam smoothing and cascade trigger block
package bsc_pkg;
    typedef struct packed {
        logic [7:0] smooth;
        logic [7:0] inv_smooth;
    } bsc_smooth_t;
    typedef struct packed {
        logic cascade_en;
        logic func_master;
        logic [15:0] master_cycle_ms;
        logic [15:0] slave_delay_us;
    } bsc_cascade_t;
    typedef struct packed {
        logic dir_in;
        logic light_dark;
        logic [7:0] out_func;
        logic [7:0] in_func;
    } bsc_pin_cfg_t;
    typedef struct packed {
        logic wr;
        logic obj;
        logic [15:0] addr;
        logic [15:0] count;
        logic [7:0] sub;
        logic [31:0] data;
    } bsc_req_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] addr;
        logic [15:0] count;
        logic [31:0] data;
    } bsc_rsp_t;
    typedef enum logic [1:0] {
        BSC_IDLE = 2'b00,
        BSC_WAIT = 2'b01,
        BSC_SCAN = 2'b10
    } bsc_state_t;
endpackage

// >>> design/bsc_run_filter.sv
// Run-length filter: drops runs of one beam state shorter than a count
`timescale 1ns/1ps
`include "bsc_params.svh"
module bsc_run_filter
    import bsc_pkg::*;
#(
    parameter int N_BEAMS = 32
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [N_BEAMS-1:0] beams_i,
    input wire bsc_smooth_t cfg_i,
    output logic [N_BEAMS-1:0] beams_o,
    output logic done_o
);
    logic [N_BEAMS-1:0] beams_r, beams_nxt;
    logic done_r, done_nxt;
    // Run length each beam belongs to, found by scanning out both ways
    function automatic logic [N_BEAMS-1:0] filt(input logic [N_BEAMS-1:0] v, input logic [7:0] lim,
                                              input logic val);
        logic [N_BEAMS-1:0] r;
        int len;
        int k;
        r = v;
        for (int i = 0; i < N_BEAMS; i++) begin
            len = 0;
            if (v[i] == val) begin
                k = i;
                while (k >= 0 && v[k] == val) begin
                    len++;
                    k--;
                end
                k = i + 1;
                while (k < N_BEAMS && v[k] == val) begin
                    len++;
                    k++;
                end
                if (lim > 8'h01 && len < int'(lim)) begin
                    r[i] = ~val;
                end
            end
        end
        return r;
    endfunction
    always_comb begin
        beams_nxt = filt(beams_i, cfg_i.smooth, 1'b1);
        beams_nxt = filt(beams_nxt, cfg_i.inv_smooth, 1'b0);
        if (!start_i) begin
            beams_nxt = beams_r;
        end
        done_nxt = start_i;
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            beams_r <= '0;
            done_r <= 1'b0;
        end else begin
            beams_r <= beams_nxt;
            done_r <= done_nxt;
        end
    end
    assign beams_o = beams_r;
    assign done_o = done_r;
    a_pass_thru: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (start_i && cfg_i.smooth <= 8'h01 && cfg_i.inv_smooth <= 8'h01) |=> beams_o == $past(beams_i))
        else $error("beams altered with smoothing off");
endmodule // bsc_run_filter

// >>> design/bsc_cascade.sv
// Beam smoothing, configuration port and cascade trigger logic
// Contract
// - Ignore interrupted beam groups shorter than the smoothing count.
// - Ignore free beam groups shorter than the inverted smoothing count.
// - Smoothing count sits in bits 15:8 of configuration word 71.
// - Inverted smoothing count sits in bits 7:0 of that word.
// - Object 2100 subindex 3 and 4 reach the two counts.
// - Parameter 0x47 written as two registers; acknowledge echoes address and count.
// - Cascade operation only when cascading enable is set.
// - Function type 1 makes this curtain the trigger master.
// - Master repeats trigger every master cycle time in milliseconds.
// - Function type 0 makes a slave that waits for the trigger.
// - Slave starts scan the programmed microsecond delay after trigger.
// - Master drives the shared pin as output, function code 3.
// - Slave takes the shared pin as input, function code 1.
// - Trigger output uses light switching polarity in every setting; the input is inverted when light_dark selects dark switching.
`timescale 1ns/1ps
`include "bsc_params.svh"
module bsc_cascade
    import bsc_pkg::*;
#(
    parameter int N_BEAMS = 32,
    parameter int CYC_PER_MS = `BSC_CYC_PER_MS,
    parameter int CYC_PER_US = `BSC_CYC_PER_US
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire bsc_req_t req_i,
    output bsc_rsp_t rsp_o,
    input wire bsc_cascade_t casc_i,
    input wire bsc_pin_cfg_t pin_cfg_i,
    input wire logic free_scan_i,
    input wire logic [N_BEAMS-1:0] beams_i,
    input wire logic scan_done_i,
    input wire logic trig_pin_i,
    output logic trig_pin_o,
    output logic trig_pin_oe_n_o,
    output logic scan_start_o,
    output logic [N_BEAMS-1:0] beams_o,
    output logic beams_valid_o
);
    bsc_rsp_t rsp_r, rsp_nxt;
    logic [31:0] cfg_r, cfg_nxt;
    bsc_smooth_t smooth_cfg;
    bsc_state_t state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] per_r, per_nxt;
    logic [31:0] pulse_r, pulse_nxt;
    logic trig_r, trig_nxt, oe_n_r, oe_n_nxt, start_r, start_nxt, pin_d_r;
    logic is_master, is_slave, pin_level, trig_edge;
    assign smooth_cfg.smooth = cfg_r[`BSC_SMOOTH_POS +: 8];
    assign smooth_cfg.inv_smooth = cfg_r[`BSC_INV_POS +: 8];
    always_comb begin
        cfg_nxt = cfg_r;
        rsp_nxt = '0;
        if (req_i.wr && !req_i.obj) begin
            rsp_nxt.addr = req_i.addr;
            rsp_nxt.count = req_i.count;
            rsp_nxt.ack = 1'b1;
            if (req_i.addr == `BSC_SMOOTH_CFG_ADDR && req_i.count == `BSC_SMOOTH_CFG_REGS) begin
                cfg_nxt[`BSC_SMOOTH_POS +: 8] = req_i.data[15:8];
                cfg_nxt[`BSC_INV_POS +: 8] = req_i.data[7:0];
            end else begin
                rsp_nxt.err = 1'b1;
            end
        end else if (req_i.obj) begin
            rsp_nxt.ack = 1'b1;
            rsp_nxt.addr = req_i.addr;
            rsp_nxt.count = {8'h00, req_i.sub};
            if (req_i.addr != `BSC_OBJ_INDEX) begin
                rsp_nxt.err = 1'b1;
            end else if (req_i.sub == `BSC_OBJ_SUB_SMOOTH) begin
                rsp_nxt.data = {24'h00_0000, smooth_cfg.smooth};
                if (req_i.wr) begin
                    cfg_nxt[`BSC_SMOOTH_POS +: 8] = req_i.data[7:0];
                end
            end else if (req_i.sub == `BSC_OBJ_SUB_INV) begin
                rsp_nxt.data = {24'h00_0000, smooth_cfg.inv_smooth};
                if (req_i.wr) begin
                    cfg_nxt[`BSC_INV_POS +: 8] = req_i.data[7:0];
                end
            end else begin
                rsp_nxt.err = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_r <= `BSC_SMOOTH_CFG_RST;
            rsp_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            rsp_r <= rsp_nxt;
        end
    end
    assign rsp_o = rsp_r;

    // cascade gate, master, slave, pin setup
    assign is_master = casc_i.cascade_en && casc_i.func_master == `BSC_FUNC_MASTER
                       && pin_cfg_i.dir_in == `BSC_PIN_DIR_OUT && pin_cfg_i.out_func == `BSC_PIN_OUT_TRIGGER;
    assign is_slave = casc_i.cascade_en && casc_i.func_master == `BSC_FUNC_SLAVE
                      && pin_cfg_i.dir_in == `BSC_PIN_DIR_IN && pin_cfg_i.in_func == `BSC_PIN_IN_TRIGGER;
    assign pin_level = trig_pin_i ^ (pin_cfg_i.light_dark != `BSC_PIN_LIGHT_SW);
    assign trig_edge = pin_level && !pin_d_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        per_nxt = per_r;
        pulse_nxt = (pulse_r != 32'h0000_0000) ? pulse_r - 32'h0000_0001 : pulse_r;
        start_nxt = 1'b0;
        oe_n_nxt = !is_master;
        trig_nxt = 1'b0;
        if (is_master) begin
            if (per_r == 32'h0000_0000) begin
                per_nxt = 32'(casc_i.master_cycle_ms) * 32'(CYC_PER_MS) - 32'h0000_0001;
                pulse_nxt = 32'(`BSC_TRIG_PULSE_CYC);
                start_nxt = casc_i.master_cycle_ms != 16'h0000;
            end else begin
                per_nxt = per_r - 32'h0000_0001;
            end
            trig_nxt = pulse_nxt != 32'h0000_0000;
            state_nxt = BSC_IDLE;
        end else if (is_slave) begin
            case (state_r)
                BSC_IDLE: begin
                    if (trig_edge) begin
                        cnt_nxt = 32'(casc_i.slave_delay_us) * 32'(CYC_PER_US);
                        state_nxt = BSC_WAIT;
                    end
                end
                BSC_WAIT: begin
                    if (cnt_r <= 32'h0000_0001) begin
                        start_nxt = 1'b1;
                        state_nxt = BSC_SCAN;
                    end else begin
                        cnt_nxt = cnt_r - 32'h0000_0001;
                    end
                end
                BSC_SCAN: begin
                    if (scan_done_i) begin
                        state_nxt = BSC_IDLE;
                    end
                end
                default: state_nxt = BSC_IDLE;
            endcase
        end else begin
            start_nxt = free_scan_i;
            state_nxt = BSC_IDLE;
        end
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= BSC_IDLE;
            cnt_r <= '0;
            per_r <= '0;
            pulse_r <= '0;
            start_r <= 1'b0;
            trig_r <= 1'b0;
            oe_n_r <= 1'b1;
            pin_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            pulse_r <= pulse_nxt;
            start_r <= start_nxt;
            trig_r <= trig_nxt;
            oe_n_r <= oe_n_nxt;
            pin_d_r <= pin_level;
        end
    end
    assign trig_pin_o = trig_r;
    assign trig_pin_oe_n_o = oe_n_r;
    assign scan_start_o = start_r;

    bsc_run_filter #(.N_BEAMS(N_BEAMS)) u_filter (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .start_i(scan_done_i),
        .beams_i(beams_i),
        .cfg_i(smooth_cfg),
        .beams_o(beams_o),
        .done_o(beams_valid_o)
    );

    a_reg_echo: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (req_i.wr && !req_i.obj) |=> rsp_o.ack && rsp_o.addr == $past(req_i.addr) && rsp_o.count == $past(req_i.count))
        else $error("write not echoed");
    a_smooth_byte: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (req_i.wr && !req_i.obj && req_i.addr == 16'h0047 && req_i.count == 16'h0002)
        |=> smooth_cfg.smooth == $past(req_i.data[15:8]))
        else $error("smoothing byte not stored");
    a_inv_byte: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (req_i.wr && !req_i.obj && req_i.addr == 16'h0047 && req_i.count == 16'h0002)
        |=> smooth_cfg.inv_smooth == $past(req_i.data[7:0]))
        else $error("inverted byte not stored");
    a_obj_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (req_i.obj && !req_i.wr && req_i.addr == 16'h2100 && req_i.sub == 8'h03)
        |=> rsp_o.data[7:0] == smooth_cfg.smooth && !rsp_o.err)
        else $error("object read wrong");
    a_no_cascade: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !casc_i.cascade_en |=> trig_pin_oe_n_o)
        else $error("pin driven without cascading");
    a_master_drive: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        is_master |=> !trig_pin_oe_n_o)
        else $error("master not driving pin");
    a_slave_wait: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (is_slave && state_r == BSC_IDLE && !trig_edge) |=> !scan_start_o)
        else $error("slave scanned without trigger");
    // Delay checked as load, count down and start, so any programmed delay is covered
    a_slave_delay: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (is_slave && state_r == BSC_IDLE && trig_edge)
        |=> state_r == BSC_WAIT && cnt_r == 32'($past(casc_i.slave_delay_us)) * 32'(CYC_PER_US))
        else $error("slave delay not loaded");
    a_delay_count: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (is_slave && state_r == BSC_WAIT && cnt_r > 32'h0000_0001)
        |=> state_r == BSC_WAIT && cnt_r == $past(cnt_r) - 32'h0000_0001 && !scan_start_o)
        else $error("slave delay not counting");
    a_delay_start: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (is_slave && state_r == BSC_WAIT && cnt_r <= 32'h0000_0001) |=> scan_start_o && state_r == BSC_SCAN)
        else $error("slave scan not started");
    a_one_scan: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (state_r == BSC_SCAN && is_slave) |=> !scan_start_o)
        else $error("second scan before done");
    a_master_trig: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (is_master && $past(is_master) && scan_start_o) |-> trig_pin_o)
        else $error("master start without trigger");
    c_master: cover property (@(posedge clk_sys_i) is_master && scan_start_o);
    c_slave: cover property (@(posedge clk_sys_i) is_slave && scan_start_o);
    c_write: cover property (@(posedge clk_sys_i) rsp_o.ack && !rsp_o.err);
endmodule // bsc_cascade

// >>> sim/bsc_far_curtain.sv
// Far-side model: upstream trigger curtain and scan head
`timescale 1ns/1ps
module bsc_far_curtain #(
    parameter int SCAN_CYC = 12
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic fire_i,
    input wire logic scan_start_i,
    output logic trig_pin_o,
    output logic scan_done_o
);
    int tcnt;
    int scnt;
    always @(negedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tcnt <= 0;
            scnt <= 0;
            trig_pin_o <= 1'b0;
            scan_done_o <= 1'b0;
        end else begin
            tcnt <= fire_i ? 10 : (tcnt > 0 ? tcnt - 1 : 0);
            trig_pin_o <= fire_i || tcnt > 1;
            scnt <= scan_start_i ? SCAN_CYC : (scnt > 0 ? scnt - 1 : 0);
            scan_done_o <= scnt == 1;
        end
    end
endmodule // bsc_far_curtain

// >>> sim/tb_bsc_cascade.sv
// Self-checking bench for the smoothing filter and cascade trigger
`timescale 1ns/1ps
`include "bsc_params.svh"
`define TB_CHK(g, e, what) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: %s", $time, what); end end
module tb_bsc_cascade
    import bsc_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    bsc_req_t req = '0;
    bsc_rsp_t rsp;
    bsc_rsp_t got;
    bsc_cascade_t casc = '0;
    bsc_pin_cfg_t pin = '0;
    logic free_scan = 1'b0;
    logic tb_done = 1'b0;
    logic fire = 1'b0;
    logic [15:0] beams = 16'h0000;
    logic [15:0] bout;
    logic p_pin;
    logic p_done;
    logic d_pin;
    logic d_oe_n;
    logic start;
    logic bvalid;
    int failures = 0;
    int n_compared = 0;
    int n;
    int n2;
    wire logic pin_line = d_oe_n ? p_pin : d_pin;

    always #25 clk_sys_i = ~clk_sys_i;

    bsc_cascade #(.N_BEAMS(16), .CYC_PER_MS(20), .CYC_PER_US(20)) bsc_cascade_i (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .req_i(req), .rsp_o(rsp), .casc_i(casc), .pin_cfg_i(pin), .free_scan_i(free_scan),
        .beams_i(beams), .scan_done_i(p_done | tb_done), .trig_pin_i(pin_line), .trig_pin_o(d_pin),
        .trig_pin_oe_n_o(d_oe_n), .scan_start_o(start), .beams_o(bout), .beams_valid_o(bvalid));
    bsc_far_curtain bsc_far_curtain_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .fire_i(fire),
        .scan_start_i(start), .trig_pin_o(p_pin), .scan_done_o(p_done));

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic access(input logic wr, input logic obj, input logic [15:0] addr, input logic [15:0] cnt,
            input logic [7:0] sub, input logic [31:0] data);
        @(negedge clk_sys_i);
        req = '{wr: wr, obj: obj, addr: addr, count: cnt, sub: sub, data: data};
        @(negedge clk_sys_i);
        #1;
        req = '0;
        if (rsp.ack !== 1'b1) @(negedge clk_sys_i) #1;
        got = rsp;
        `TB_CHK(got.ack, 1'b1, "no acknowledge")
    endtask

    // Counts falling edges until a watched output reaches a level
    task automatic wait_sig(input int sel, input logic val, input int lim, output int cnt);
        logic s;
        cnt = 0;
        s = ~val;
        while (s !== val && cnt < lim) begin
            @(negedge clk_sys_i);
            #1;
            cnt++;
            s = sel == 0 ? start : sel == 1 ? d_pin : bvalid;
        end
    endtask

    task automatic filt(input logic [15:0] counts, input logic [15:0] b, input logic [15:0] exp);
        access(1'b1, 1'b0, `BSC_SMOOTH_CFG_ADDR, `BSC_SMOOTH_CFG_REGS, 8'h00, {16'h0000, counts});
        beams = b;
        tb_done = 1'b1;
        @(negedge clk_sys_i);
        #1;
        tb_done = 1'b0;
        `TB_CHK(bvalid, 1'b1, "filtered beams not valid")
        `TB_CHK(bout, exp, "filtered beams")
    endtask

    task automatic pulse_fire();
        @(negedge clk_sys_i);
        fire <= 1'b1;
        @(negedge clk_sys_i);
        fire <= 1'b0;
    endtask

    initial begin
        repeat (8) @(negedge clk_sys_i);
        `TB_CHK(d_oe_n, 1'b1, "pin driven in reset")
        reset_n_i = 1'b1;
        access(1'b1, 1'b0, `BSC_SMOOTH_CFG_ADDR, `BSC_SMOOTH_CFG_REGS, 8'h00, 32'h0000_0401);
        `TB_CHK({got.err, got.addr, got.count}, {1'b0, 16'h0047, 16'h0002}, "write echo")
        access(1'b0, 1'b1, `BSC_OBJ_INDEX, 16'h0000, `BSC_OBJ_SUB_SMOOTH, 32'h0000_0000);
        `TB_CHK(got.data[7:0], 8'h04, "smoothing count")
        access(1'b0, 1'b1, `BSC_OBJ_INDEX, 16'h0000, `BSC_OBJ_SUB_INV, 32'h0000_0000);
        `TB_CHK(got.data[7:0], 8'h01, "inverted count")
        for (int i = 0; i < 4; i++) begin
            access(1'b1, i > 1, i == 0 ? 16'h0048 : i == 2 ? 16'h2101 : i == 3 ? 16'h2100 : 16'h0047,
                i == 1 ? 16'h0001 : 16'h0002, i == 3 ? 8'h05 : 8'h03, 32'h0000_0909);
            `TB_CHK(got.err, 1'b1, "bad request taken")
        end
        access(1'b0, 1'b1, `BSC_OBJ_INDEX, 16'h0000, `BSC_OBJ_SUB_SMOOTH, 32'h0000_0000);
        `TB_CHK(got.data[7:0], 8'h04, "refused write stored")
        access(1'b1, 1'b1, `BSC_OBJ_INDEX, 16'h0000, `BSC_OBJ_SUB_INV, 32'h0000_0006);
        access(1'b0, 1'b1, `BSC_OBJ_INDEX, 16'h0000, `BSC_OBJ_SUB_INV, 32'h0000_0000);
        `TB_CHK(got.data[7:0], 8'h06, "object write")
        filt(16'h0400, 16'h0778, 16'h0078);
        filt(16'h0004, 16'hF8F0, 16'hFFF0);
        filt(16'h0101, 16'h5555, 16'h5555);
        filt(16'h0000, 16'hA5A5, 16'hA5A5);
        free_scan = 1'b1;
        wait_sig(0, 1'b1, 3, n);
        `TB_CHK(start, 1'b1, "free scan")
        free_scan = 1'b0;
        pin = '{dir_in: `BSC_PIN_DIR_OUT, light_dark: `BSC_PIN_LIGHT_SW, out_func: `BSC_PIN_OUT_TRIGGER, in_func: 8'h00};
        casc = '{cascade_en: 1'b1, func_master: `BSC_FUNC_MASTER, master_cycle_ms: 16'd15, slave_delay_us: 16'd0};
        wait_sig(1, 1'b1, 400, n);
        `TB_CHK({d_oe_n, start}, 2'b01, "master trigger")
        wait_sig(1, 1'b0, 400, n);
        wait_sig(1, 1'b1, 400, n2);
        `TB_CHK(n, `BSC_TRIG_PULSE_CYC, "pulse width")
        `TB_CHK(n + n2, 15 * 20, "trigger period")
        wait_sig(1, 1'b0, 400, n);
        pin.out_func = `BSC_PIN_IN_TRIGGER;
        wait_sig(1, 1'b1, 400, n);
        `TB_CHK(n, 400, "trigger with wrong function")
        pin.out_func = `BSC_PIN_OUT_TRIGGER;
        casc.cascade_en = 1'b0;
        wait_sig(1, 1'b1, 400, n);
        `TB_CHK(n, 400, "trigger without cascading")
        pin = '{dir_in: `BSC_PIN_DIR_IN, light_dark: `BSC_PIN_LIGHT_SW, out_func: 8'h00, in_func: `BSC_PIN_IN_TRIGGER};
        casc = '{cascade_en: 1'b1, func_master: `BSC_FUNC_SLAVE, master_cycle_ms: 16'd15, slave_delay_us: 16'd3};
        free_scan = 1'b1;
        wait_sig(0, 1'b1, 100, n);
        `TB_CHK({n, d_oe_n}, {32'd100, 1'b1}, "slave scanned freely")
        free_scan = 1'b0;
        pulse_fire();
        repeat (20) @(negedge clk_sys_i);
        pulse_fire();
        wait_sig(0, 1'b1, 100, n);
        `TB_CHK(n, 3 * 20 + 1 - 22, "delay after trigger")
        repeat (2) @(negedge clk_sys_i);
        pulse_fire();
        wait_sig(0, 1'b1, 150, n);
        `TB_CHK(n, 150, "trigger taken during scan")
        pulse_fire();
        wait_sig(0, 1'b1, 100, n);
        `TB_CHK(n, 3 * 20 + 1, "second scan delay")
        tally_and_finish();
    end

    initial begin
        #1_000_000;
        failures++;
        tally_and_finish();
    end
endmodule // tb_bsc_cascade
